/* design/flash_lat_pkg.sv */
// shared constants, latency tables and lookup helpers for the serial flash read link
// assumes both ends run on one 250 MHz clock and agree on the tables held here
package flash_lat_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int SCK_HALF_NS   = 32;
	localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SCK_HALF_LAST = 4'(SCK_HALF_CYC - 1);

	// ----------------------------------------------------------------
	// table layout
	// ----------------------------------------------------------------
	localparam int         SDR_LEN       = 88;
	localparam int         DDR_LEN       = 44;
	localparam logic [7:0] UNSUPPORTED   = 8'hff;
	localparam logic [7:0] HDR_FIRST_OP  = 8'h06;
	localparam logic [7:0] ROW_COUNT_OFS = 8'h02;
	localparam logic [7:0] SDR_ROW_C11   = 8'h12;
	localparam logic [7:0] SDR_ROW_C00   = 8'h20;
	localparam logic [7:0] SDR_ROW_C01   = 8'h2e;
	localparam logic [7:0] SDR_ROW_C10   = 8'h3c;
	localparam logic [7:0] SDR_ROW_C10HI = 8'h4a;
	localparam logic [7:0] DDR_ROW_C11   = 8'h0c;
	localparam logic [7:0] DDR_ROW_C00   = 8'h14;
	localparam logic [7:0] DDR_ROW_C01   = 8'h1c;
	localparam logic [7:0] DDR_ROW_C10   = 8'h24;

	// ----------------------------------------------------------------
	// framing constants
	// ----------------------------------------------------------------
	localparam logic [7:0] TABLE_READ_OP  = 8'h5e;
	localparam logic [7:0] TABLE_READ_LAT = 8'h08;
	localparam logic [5:0] OPC_BITS       = 6'h08;
	localparam logic [5:0] ADDR3_BITS     = 6'h18;
	localparam logic [5:0] ADDR4_BITS     = 6'h20;

	// single data rate latency table, byte 0 first
	localparam logic [0:SDR_LEN-1][7:0] SDR_TABLE = {
		8'h90, 8'h56, 8'h06, 8'h0e, 8'h46, 8'h43, 8'h03, 8'h13, 8'h0b, 8'h0c, 8'h3b, 8'h3c, 8'h6b, 8'h6c, 8'hbb, 8'hbc,
		8'heb, 8'hec, 8'h32, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h02, 8'h01,
		8'h50, 8'h00, 8'hff, 8'hff, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h08, 8'h04, 8'h00, 8'h02, 8'h04, 8'h5a, 8'h01,
		8'hff, 8'hff, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h08, 8'h04, 8'h01, 8'h02, 8'h04, 8'h68, 8'h02, 8'hff, 8'hff,
		8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h08, 8'h04, 8'h02, 8'h02, 8'h05, 8'h85, 8'h02, 8'hff, 8'hff, 8'h00, 8'h08,
		8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

	// double data rate latency table, byte 0 first
	localparam logic [0:DDR_LEN-1][7:0] DDR_TABLE = {
		8'h9a, 8'h2a, 8'h05, 8'h08, 8'h46, 8'h43, 8'h0d, 8'h0e, 8'hbd, 8'hbe, 8'hed, 8'hee, 8'h32, 8'h03, 8'h04, 8'h01,
		8'h02, 8'h02, 8'h01, 8'h03, 8'h42, 8'h00, 8'h04, 8'h02, 8'h02, 8'h04, 8'h01, 8'h06, 8'h42, 8'h01, 8'h04, 8'h04,
		8'h02, 8'h05, 8'h01, 8'h07, 8'h42, 8'h02, 8'h04, 8'h05, 8'h02, 8'h06, 8'h01, 8'h08};

	typedef struct packed {
		logic       ok;
		logic       tbl;
		logic       ddr;
		logic       four;
		logic [2:0] kind;
	} op_info_t;

	// opcode lookup straight from the table header rows
	function automatic op_info_t decode_op(input logic [7:0] op);
		op_info_t d;
		d = '0;
		for (int i = 0; i < 12; i++) begin
			if (SDR_TABLE[6 + i] == op) begin
				d.ok   = 1'b1;
				d.kind = 3'(i >> 1);
				d.four = 1'(i & 1);
			end
		end
		for (int i = 0; i < 6; i++) begin
			if (DDR_TABLE[6 + i] == op) begin
				d.ok   = 1'b1;
				d.ddr  = 1'b1;
				d.kind = 3'(i >> 1);
				d.four = 1'(i & 1);
			end
		end
		if (op == TABLE_READ_OP) begin
			d.ok  = 1'b1;
			d.tbl = 1'b1;
		end
		return d;
	endfunction : decode_op

	// {mode, latency} cycles for a command at a latency code
	function automatic logic [15:0] cycle_counts(input op_info_t d, input logic [1:0] code, input logic hi);
		logic [7:0] base;
		logic [7:0] idx;
		base = '0;
		if (d.ddr) begin
			case (code)
				2'h0: base = DDR_ROW_C00;
				2'h1: base = DDR_ROW_C01;
				2'h2: base = DDR_ROW_C10;
				default: base = DDR_ROW_C11;
			endcase
		end else begin
			case (code)
				2'h0: base = SDR_ROW_C00;
				2'h1: base = SDR_ROW_C01;
				2'h2: base = hi ? SDR_ROW_C10HI : SDR_ROW_C10;
				default: base = SDR_ROW_C11;
			endcase
		end
		idx = base + ROW_COUNT_OFS + {4'h0, d.kind, 1'b0};
		if (d.tbl)
			return {8'h00, TABLE_READ_LAT};
		else if (d.ddr)
			return {DDR_TABLE[idx[5:0]], DDR_TABLE[idx[5:0] + 6'h01]};
		else
			return {SDR_TABLE[idx[6:0]], SDR_TABLE[idx[6:0] + 7'h01]};
	endfunction : cycle_counts

	// byte of the parameter space; bit 7 picks the double data rate table
	function automatic logic [7:0] table_byte(input logic [7:0] a);
		if (a[7])
			return (a[6:0] < 7'(DDR_LEN)) ? DDR_TABLE[a[5:0]] : UNSUPPORTED;
		else
			return (a[6:0] < 7'(SDR_LEN)) ? SDR_TABLE[a[6:0]] : UNSUPPORTED;
	endfunction : table_byte

endpackage : flash_lat_pkg

/* design/flash_link_if.sv */
// serial link between the read host and the flash end
// assumes the flash end alone drives the return line; undriven it reads high
`timescale 1ns/10ps
interface flash_link_if;
	logic sck;
	logic cs_n;
	logic mosi;
	logic miso_o;
	logic miso_oe;
	logic miso;

	// level of the return wire, pulled high when undriven
	assign miso = miso_oe ? miso_o : 1'b1;

	modport host (output sck, output cs_n, output mosi, input miso);
	modport flash (input sck, input cs_n, input mosi, output miso_o, output miso_oe);
endinterface : flash_link_if

/* design/flash_read_end.sv */
// flash end: decodes read commands, waits mode and latency cycles, returns data
// assumes link pins arrive asynchronously; lat_code comes from logic on this clock
`timescale 1ns/10ps
module flash_read_end
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// configuration and status
	input  wire logic [1:0] lat_code,
	output logic            busy,
	output logic            bad_op,
	// link
	flash_link_if.flash     link
);
	import flash_lat_pkg::*;

	typedef enum logic [2:0] {D_IDLE, D_OPC, D_ADDR, D_MODE, D_LAT, D_DATA, D_SKIP} dstate_t;

	typedef struct packed {
		dstate_t    state;
		logic       sck_s1, sck_s2, sck_s3;
		logic       cs_s1, cs_s2;
		logic       mosi_s1, mosi_s2;
		logic [7:0] sh;
		logic [5:0] left;
		op_info_t   info;
		logic [7:0] mode;
		logic [7:0] lat;
		logic [31:0] addr;
		logic [7:0] obyte;
		logic [2:0] obit;
		logic       miso_o, miso_oe, busy, bad_op;
	} dev_t;

	dev_t st_r, st_nxt;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic       rise;
		logic       fall;
		logic       last;
		logic [7:0] op;
		logic [15:0] cnt;
		logic [7:0] byte_v;
		op_info_t   d;
		rise   = 1'b0;
		fall   = 1'b0;
		last   = 1'b0;
		op     = '0;
		cnt    = '0;
		byte_v = '0;
		d      = '0;
		st_nxt = st_r;
		st_nxt.bad_op  = 1'b0;
		st_nxt.sck_s1  = link.sck;
		st_nxt.sck_s2  = st_r.sck_s1;
		st_nxt.sck_s3  = st_r.sck_s2;
		st_nxt.cs_s1   = link.cs_n;
		st_nxt.cs_s2   = st_r.cs_s1;
		st_nxt.mosi_s1 = link.mosi;
		st_nxt.mosi_s2 = st_r.mosi_s1;
		rise = st_r.sck_s2 & ~st_r.sck_s3;
		fall = ~st_r.sck_s2 & st_r.sck_s3;
		last = (st_r.left == 6'h01);
		if (st_r.cs_s2) begin
			// deselected: frame over, release the return line
			st_nxt.state   = D_IDLE;
			st_nxt.miso_oe = 1'b0;
			st_nxt.busy    = 1'b0;
		end else begin
			case (st_r.state)
				D_IDLE: begin
					st_nxt.state = D_OPC;
					st_nxt.left  = OPC_BITS;
					st_nxt.busy  = 1'b1;
				end
				D_OPC: if (rise) begin
					op = {st_r.sh[6:0], st_r.mosi_s2};
					st_nxt.sh   = op;
					st_nxt.left = st_r.left - 6'h01;
					if (last) begin
						d   = decode_op(op);
						cnt = cycle_counts(d, lat_code, 1'b0);
						st_nxt.info = d;
						st_nxt.mode = cnt[15:8];
						st_nxt.lat  = cnt[7:0];
						st_nxt.left = d.four ? ADDR4_BITS : ADDR3_BITS;
						st_nxt.addr = '0;
						if (!d.ok || cnt[15:8] == UNSUPPORTED || cnt[7:0] == UNSUPPORTED) begin
							st_nxt.state  = D_SKIP;
							st_nxt.bad_op = 1'b1;
						end else begin
							st_nxt.state = D_ADDR;
						end
					end
				end
				D_ADDR: if (rise) begin
					st_nxt.addr = {st_r.addr[30:0], st_r.mosi_s2};
					st_nxt.left = st_r.left - 6'h01;
					if (last) begin
						st_nxt.obit = 3'h0;
						if (st_r.mode != 8'h00) begin
							st_nxt.state = D_MODE;
							st_nxt.left  = st_r.mode[5:0];
						end else if (st_r.lat != 8'h00) begin
							st_nxt.state = D_LAT;
							st_nxt.left  = st_r.lat[5:0];
						end else begin
							st_nxt.state = D_DATA;
						end
					end
				end
				D_MODE: if (rise) begin
					// mode bits are ignored; count them off
					st_nxt.left = st_r.left - 6'h01;
					if (last) begin
						st_nxt.state = (st_r.lat != 8'h00) ? D_LAT : D_DATA;
						st_nxt.left  = st_r.lat[5:0];
					end
				end
				D_LAT: if (rise) begin
					st_nxt.left = st_r.left - 6'h01;
					if (last)
						st_nxt.state = D_DATA;
				end
				D_DATA: if (fall) begin
					// drive one bit per falling edge, msb first
					byte_v = st_r.info.tbl ? table_byte(st_r.addr[7:0]) : st_r.addr[7:0];
					st_nxt.miso_oe = 1'b1;
					if (st_r.obit == 3'h0) begin
						st_nxt.miso_o = byte_v[7];
						st_nxt.obyte  = {byte_v[6:0], 1'b0};
					end else begin
						st_nxt.miso_o = st_r.obyte[7];
						st_nxt.obyte  = {st_r.obyte[6:0], 1'b0};
					end
					st_nxt.obit = st_r.obit + 3'h1;
					if (st_r.obit == 3'h7)
						st_nxt.addr = st_r.addr + 32'h1;
				end
				D_SKIP: st_nxt.state = D_SKIP;
				default: st_nxt.state = D_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_r       <= '0;
			st_r.state <= D_IDLE;
			st_r.sck_s1 <= 1'b0;
			st_r.cs_s1 <= 1'b1;
			st_r.cs_s2 <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign busy         = st_r.busy;
	assign bad_op       = st_r.bad_op;
	assign link.miso_o  = st_r.miso_o;
	assign link.miso_oe = st_r.miso_oe;

endmodule : flash_read_end

/* design/flash_read_host.sv */
// read host: frames one read command on the serial link and collects the data
// assumes the return line is asynchronous; user requests come from this clock
`timescale 1ns/10ps

module flash_read_host
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// request
	input  wire logic        start,
	input  wire logic [7:0]  opcode,
	input  wire logic [31:0] addr,
	input  wire logic [1:0]  lat_code,
	input  wire logic        band_hi,
	input  wire logic [7:0]  nbytes,
	// answer
	output logic             busy,
	output logic [7:0]       rdata,
	output logic             rvalid,
	output logic             done,
	output logic             refused,
	// link
	flash_link_if.host       link
);
	import flash_lat_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {H_IDLE, H_SHIFT, H_MODE, H_LAT, H_DATA, H_END, H_GAP} hstate_t;

	typedef struct packed {
		hstate_t     state;
		logic [3:0]  div;
		logic        sck;
		logic        cs_n;
		logic        mosi;
		logic [39:0] sh;
		logic [11:0] left;
		logic [7:0]  mode;
		logic [7:0]  lat;
		logic [11:0] dbits;
		logic [7:0]  rbyte;
		logic [2:0]  rbit;
		logic        miso_s1;
		logic        miso_s2;
		logic [7:0]  rdata;
		logic        rvalid;
		logic        done;
		logic        refused;
		logic        busy;
	} host_t;

	host_t st_r, st_nxt;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic        tick;
		logic        rise;
		logic        fall;
		logic        last;
		logic [7:0]  rb;
		logic [15:0] cnt;
		op_info_t    d;
		tick = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		last = 1'b0;
		rb   = '0;
		cnt  = '0;
		d    = '0;
		st_nxt = st_r;
		st_nxt.rvalid  = 1'b0;
		st_nxt.done    = 1'b0;
		st_nxt.refused = 1'b0;

		// return line synchroniser
		st_nxt.miso_s1 = link.miso;
		st_nxt.miso_s2 = st_r.miso_s1;

		// serial clock divider, runs inside a frame and on through the deselect gap after it
		tick = (st_r.div == SCK_HALF_LAST);
		rise = tick & ~st_r.sck & (st_r.state != H_IDLE) & (st_r.state != H_GAP);
		fall = tick & st_r.sck;
		last = (st_r.left == 12'h001);
		if (st_r.state != H_IDLE) begin
			st_nxt.div = tick ? 4'h0 : st_r.div + 4'h1;
			if (rise | fall)
				st_nxt.sck = ~st_r.sck;
		end

		// next outgoing bit on each falling edge; zeros follow the address
		if (fall) begin
			st_nxt.sh   = {st_r.sh[38:0], 1'b0};
			st_nxt.mosi = st_r.sh[38];
		end

		case (st_r.state)
			H_IDLE: begin
				st_nxt.div = 4'h0;
				st_nxt.sck = 1'b0;
				if (start) begin
					d   = decode_op(opcode);
					cnt = cycle_counts(d, lat_code, band_hi);
					if (!d.ok || cnt[15:8] == UNSUPPORTED || cnt[7:0] == UNSUPPORTED) begin
						// unknown or unsupported in this band: no frame at all
						st_nxt.refused = 1'b1;
					end else begin
						st_nxt.state = H_SHIFT;
						st_nxt.busy  = 1'b1;
						st_nxt.cs_n  = 1'b0;
						st_nxt.sh    = d.four ? {opcode, addr} : {opcode, addr[23:0], 8'h00};
						st_nxt.mosi  = opcode[7];
						st_nxt.left  = d.four ? {6'h00, ADDR4_BITS} + {6'h00, OPC_BITS}
						                      : {6'h00, ADDR3_BITS} + {6'h00, OPC_BITS};
						st_nxt.mode  = cnt[15:8];
						st_nxt.lat   = cnt[7:0];
						st_nxt.dbits = {(nbytes == 8'h00), nbytes, 3'h0};
						st_nxt.rbit  = 3'h0;
					end
				end
			end

			// opcode and address bits
			H_SHIFT: if (rise) begin
				st_nxt.left = st_r.left - 12'h001;
				if (last) begin
					if (st_r.mode != 8'h00) begin
						st_nxt.state = H_MODE;
						st_nxt.left  = {4'h0, st_r.mode};
					end else if (st_r.lat != 8'h00) begin
						st_nxt.state = H_LAT;
						st_nxt.left  = {4'h0, st_r.lat};
					end else begin
						st_nxt.state = H_DATA;
						st_nxt.left  = st_r.dbits;
					end
				end
			end

			// mode cycles, driven low
			H_MODE: if (rise) begin
				st_nxt.left = st_r.left - 12'h001;
				if (last) begin
					if (st_r.lat != 8'h00) begin
						st_nxt.state = H_LAT;
						st_nxt.left  = {4'h0, st_r.lat};
					end else begin
						st_nxt.state = H_DATA;
						st_nxt.left  = st_r.dbits;
					end
				end
			end

			// latency cycles, nothing sampled
			H_LAT: if (rise) begin
				st_nxt.left = st_r.left - 12'h001;
				if (last) begin
					st_nxt.state = H_DATA;
					st_nxt.left  = st_r.dbits;
				end
			end

			// sample one bit per rising edge, msb first
			H_DATA: if (rise) begin
				rb = {st_r.rbyte[6:0], st_r.miso_s2};
				st_nxt.rbyte = rb;
				st_nxt.rbit  = st_r.rbit + 3'h1;
				st_nxt.left  = st_r.left - 12'h001;
				if (st_r.rbit == 3'h7) begin
					st_nxt.rdata  = rb;
					st_nxt.rvalid = 1'b1;
				end
				if (last)
					st_nxt.state = H_END;
			end

			// finish the last clock, then deselect
			H_END: if (fall) begin
				st_nxt.state = H_GAP;
				st_nxt.cs_n  = 1'b1;
				st_nxt.mosi  = 1'b0;
			end

			// deselect time so the far end sees the frame end
			H_GAP: if (tick) begin
				st_nxt.state = H_IDLE;
				st_nxt.busy  = 1'b0;
				st_nxt.done  = 1'b1;
			end

			default: st_nxt.state = H_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_r       <= '0;
			st_r.state <= H_IDLE;
			st_r.cs_n  <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from flops
	// ----------------------------------------------------------------
	assign busy      = st_r.busy;
	assign rdata     = st_r.rdata;
	assign rvalid    = st_r.rvalid;
	assign done      = st_r.done;
	assign refused   = st_r.refused;
	assign link.sck  = st_r.sck;
	assign link.cs_n = st_r.cs_n;
	assign link.mosi = st_r.mosi;

endmodule : flash_read_host

/* test/flash_link_asserts.sv */
// concurrent checks on the wires of the serial flash read link
// assumes it sits beside the link interface in the bench top, one clock domain
`timescale 1ns/10ps
module flash_link_asserts (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// link
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// one half period of the serial clock, high or low
	sequence s_hi8; sck [*8]; endsequence
	sequence s_lo8; !sck [*8]; endsequence

	property p_sck_idle; cs_n |-> !sck; endproperty
	property p_sck_high; $rose(sck) |-> s_hi8 ##1 !sck; endproperty
	property p_sck_low; $fell(sck) && !cs_n |-> s_lo8; endproperty
	property p_cs_lead; $fell(cs_n) |-> s_lo8; endproperty
	property p_mosi_hold; $rose(sck) |=> $stable(mosi) [*7]; endproperty
	property p_miso_hold; $rose(sck) && miso_oe |=> $stable(miso_o) [*7]; endproperty
	property p_oe_start; $rose(miso_oe) |-> !sck && !cs_n; endproperty
	property p_oe_release; cs_n [*8] |-> !miso_oe; endproperty
	property p_miso_edge; $changed(miso_o) && miso_oe && $past(miso_oe) |-> !sck; endproperty

	a_sck_idle: assert property (p_sck_idle) else $error("serial clock high outside a frame");
	a_sck_high: assert property (p_sck_high) else $error("serial clock high phase not 8 cycles");
	a_sck_low: assert property (p_sck_low) else $error("serial clock low phase short");
	a_cs_lead: assert property (p_cs_lead) else $error("first rise too soon after select");
	a_mosi_hold: assert property (p_mosi_hold) else $error("command bit moved while clock high");
	a_miso_hold: assert property (p_miso_hold) else $error("return bit moved while clock high");
	a_oe_start: assert property (p_oe_start) else $error("return drive began at wrong phase");
	a_oe_release: assert property (p_oe_release) else $error("return line driven while deselected");
	a_miso_edge: assert property (p_miso_edge) else $error("return bit changed with clock high");
endmodule : flash_link_asserts

/* test/tb_serial_flash_read_latency_table.sv */
// bench: host and flash ends joined on one link, a second flash end driven by hand
// assumes the design package, link interface and both ends from the design folder
`timescale 1ns/10ps
module tb_serial_flash_read_latency_table;
	import flash_lat_pkg::*;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        start = 1'b0;
	logic [7:0]  opcode = 8'h00;
	logic [31:0] addr = 32'h0;
	logic [1:0]  lat_code = 2'h1;
	logic        band_hi = 1'b0;
	logic [7:0]  nbytes = 8'h01;
	logic        h_busy, rvalid, done, refused, f_busy, bad_op, f2_busy, bad_op2;
	logic [7:0]  rdata;
	logic        b_sck = 1'b0, b_cs_n = 1'b1, b_mosi = 1'b0, sck_q = 1'b0, cs_q = 1'b1;
	logic [31:0] sh = '0, hdr = '0;
	int          miscompares = 0, num_checks = 0, fcnt = 0, bad_seen = 0, oe2_seen = 0;
	flash_link_if link ();
	flash_link_if link2 ();

	flash_read_host i_flash_read_host (.clock(clock), .rst_n(rst_n), .start(start), .opcode(opcode), .addr(addr),
		.lat_code(lat_code), .band_hi(band_hi), .nbytes(nbytes), .busy(h_busy), .rdata(rdata), .rvalid(rvalid),
		.done(done), .refused(refused), .link(link.host));
	flash_read_end i_flash_read_end (.clock(clock), .rst_n(rst_n), .lat_code(lat_code), .busy(f_busy),
		.bad_op(bad_op), .link(link.flash));
	flash_read_end i_flash_read_end_2 (.clock(clock), .rst_n(rst_n), .lat_code(2'h1), .busy(f2_busy),
		.bad_op(bad_op2), .link(link2.flash));
	flash_link_asserts i_flash_link_asserts (.clock(clock), .rst_n(rst_n), .sck(link.sck), .cs_n(link.cs_n),
		.mosi(link.mosi), .miso_o(link.miso_o), .miso_oe(link.miso_oe));

	// hand-driven link for the second flash end
	assign link2.sck  = b_sck;
	assign link2.cs_n = b_cs_n;
	assign link2.mosi = b_mosi;

	// clock source
	always #2 clock = ~clock;

	// rises per frame, first 32 command bits, faults seen on the second end
	always @(posedge clock) begin
		sck_q <= link.sck;
		cs_q  <= link.cs_n;
		if (cs_q && !link.cs_n)
			fcnt <= 0;
		else if (!link.cs_n && link.sck && !sck_q) begin
			fcnt <= fcnt + 1;
			sh   <= {sh[30:0], link.mosi};
			if (fcnt == 31)
				hdr <= {sh[30:0], link.mosi};
		end
		if (bad_op2 === 1'b1)
			bad_seen <= bad_seen + 1;
		if (link2.miso_oe === 1'b1)
			oe2_seen <= 1;
	end

	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish

	// one read frame: data bytes, clock count and command bits
	task automatic run(input logic [7:0] op, input logic [31:0] a, input logic [1:0] lc, input logic hi,
			input int n, input int ab, input int ml, input logic [63:0] ex);
		int k;
		int w;
		int fb;
		int bo;
		logic [7:0] e;
		k = 0;
		w = 0;
		fb = 0;
		bo = 0;
		@(posedge clock);
		opcode   <= op;
		addr     <= a;
		lat_code <= lc;
		band_hi  <= hi;
		nbytes   <= 8'(n);
		start    <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		while (done !== 1'b1 && w < 4000) begin
			@(posedge clock);
			#1;
			w++;
			if (f_busy === 1'b1 && h_busy === 1'b1)
				fb++;
			if (bad_op !== 1'b0)
				bo++;
			if (rvalid === 1'b1) begin
				e = (op == 8'h5e) ? ex[63 - 8 * k -: 8] : 8'(a[7:0] + k);
				chk(rdata === e, "read data");
				k++;
			end
		end
		chk(k == n && w < 4000, "byte count");
		chk(fcnt == 8 + ab + ml + 8 * n, "serial clock count");
		chk(hdr === ((ab == 32) ? {op, a[31:8]} : {op, a[23:0]}), "command bits");
		chk(fb > 0 && bo == 0 && h_busy === 1'b0 && f_busy === 1'b0, "busy or fault flag");
	endtask : run

	// a request that must be refused without a frame
	task automatic rej(input logic [7:0] op, input logic [1:0] lc, input logic hi);
		int seen;
		seen = 0;
		@(posedge clock);
		opcode   <= op;
		lat_code <= lc;
		band_hi  <= hi;
		start    <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		// the refusal pulse stands only in the cycle right after the take
		#1;
		if (refused === 1'b1)
			seen++;
		repeat (4) begin
			@(posedge clock);
			#1;
			if (refused === 1'b1)
				seen++;
			if (link.cs_n !== 1'b1)
				seen = 9;
		end
		chk(seen == 1, "refusal");
	endtask : rej

	// bit-bangs 32 bits msb first into the second flash end
	task automatic bang(input logic [31:0] wd);
		@(posedge clock);
		b_cs_n <= 1'b0;
		for (int i = 31; i >= 0; i--) begin
			b_mosi <= wd[i];
			repeat (20) @(posedge clock);
			b_sck <= 1'b1;
			repeat (20) @(posedge clock);
			b_sck <= 1'b0;
		end
		repeat (8) @(posedge clock);
		b_cs_n <= 1'b1;
		repeat (8) @(posedge clock);
	endtask : bang

	task automatic t_code01();
		run(8'h0b, 32'h000000fe, 2'h1, 1'b0, 3, 24, 8, '0);
		run(8'h3b, 32'h00000011, 2'h1, 1'b0, 1, 24, 8, '0);
		run(8'h6b, 32'h00000022, 2'h1, 1'b0, 1, 24, 8, '0);
		run(8'hbb, 32'h00000033, 2'h1, 1'b0, 2, 24, 5, '0);
		run(8'heb, 32'h00000044, 2'h1, 1'b0, 1, 24, 6, '0);
		rej(8'h03, 2'h1, 1'b0);
		$display("test code01 finished");
	endtask : t_code01

	task automatic t_code10();
		run(8'hbb, 32'h00000055, 2'h2, 1'b0, 1, 24, 6, '0);
		run(8'heb, 32'h00000066, 2'h2, 1'b0, 1, 24, 7, '0);
		run(8'h3b, 32'h00000077, 2'h2, 1'b0, 1, 24, 8, '0);
		run(8'h0c, 32'h12345678, 2'h2, 1'b0, 2, 32, 8, '0);
		rej(8'h03, 2'h2, 1'b0);
		$display("test code10 finished");
	endtask : t_code10

	task automatic t_band();
		run(8'h0b, 32'h00000088, 2'h2, 1'b1, 1, 24, 8, '0);
		rej(8'h3b, 2'h2, 1'b1);
		rej(8'h6b, 2'h2, 1'b1);
		rej(8'hbb, 2'h2, 1'b1);
		rej(8'heb, 2'h2, 1'b1);
		rej(8'h03, 2'h2, 1'b1);
		$display("test band finished");
	endtask : t_band

	task automatic t_ddr();
		run(8'h0d, 32'h00000099, 2'h3, 1'b0, 1, 24, 5, '0);
		run(8'hbd, 32'h000000aa, 2'h3, 1'b0, 1, 24, 4, '0);
		run(8'hee, 32'h0a0b0c0d, 2'h2, 1'b0, 1, 32, 9, '0);
		rej(8'h77, 2'h1, 1'b0);
		$display("test ddr finished");
	endtask : t_ddr

	// rows for codes 00b and 11b, including a frame with no mode or latency
	task automatic t_slow();
		run(8'h03, 32'h000000b1, 2'h3, 1'b0, 1, 24, 0, '0);
		run(8'heb, 32'h000000b2, 2'h0, 1'b0, 1, 24, 6, '0);
		run(8'h0d, 32'h000000b3, 2'h0, 1'b0, 1, 24, 6, '0);
		$display("test slow finished");
	endtask : t_slow

	task automatic t_tables();
		run(8'h5e, 32'h00000080, 2'h1, 1'b0, 8, 24, 8, 64'h9a2a0508_46430d0e);
		run(8'h5e, 32'h00000088, 2'h1, 1'b0, 8, 24, 8, 64'hbdbeedee_32030401);
		run(8'h5e, 32'h000000aa, 2'h1, 1'b0, 4, 24, 8, 64'h0108ffff_00000000);
		run(8'h5e, 32'h00000004, 2'h1, 1'b0, 8, 24, 8, 64'h46430313_0b0c3b3c);
		run(8'h5e, 32'h0000002e, 2'h1, 1'b0, 8, 24, 8, 64'h5a01ffff_00080008);
		run(8'h5e, 32'h0000003c, 2'h1, 1'b0, 8, 24, 8, 64'h6802ffff_00080008);
		run(8'h5e, 32'h00000046, 2'h1, 1'b0, 8, 24, 8, 64'h04020205_8502ffff);
		$display("test tables finished");
	endtask : t_tables

	task automatic t_fault();
		bang({8'h03, 24'h000010});
		chk(bad_seen == 1 && oe2_seen == 0, "marked command not rejected");
		bang({8'h77, 24'h000020});
		chk(bad_seen == 2 && oe2_seen == 0, "unknown command not rejected");
		$display("test fault finished");
	endtask : t_fault

	// main sequence
	initial begin
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		#1;
		chk(link.cs_n === 1'b1 && link.sck === 1'b0 && link.miso_oe === 1'b0 && h_busy === 1'b0, "reset");
		t_code01();
		t_code10();
		t_band();
		t_ddr();
		t_slow();
		t_tables();
		t_fault();
		tally_and_finish();
	end

	// watchdog against a hung frame
	initial begin
		repeat (60000) @(posedge clock);
		miscompares++;
		$display("ERROR %0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule : tb_serial_flash_read_latency_table
